/* File: status_reg_pkg.sv */
// Purpose: shared constants and carriers for the flash status register bank
// Assumes: one clock domain, synchronous active-high reset
// Notes: instruction codes arrive already decoded as one-cycle strobes

package status_reg_pkg;

  // bit positions, first register
  localparam int P_PROT_LOW = 7;
  localparam int P_GRAN = 6;
  localparam int P_DIR = 5;
  localparam int P_BP_HI = 4;
  localparam int P_BP_LO = 2;
  localparam int P_WEL = 1;
  localparam int P_BUSY = 0;
  // bit positions, second register
  localparam int P_SUSP = 7;
  localparam int P_CMP = 6;
  localparam int P_LOCK_HI = 5;
  localparam int P_LOCK_LO = 3;
  localparam int P_QUAD = 1;
  localparam int P_PROT_HIGH = 0;
  // bit positions, third register
  localparam int P_PIN_ROLE = 7;
  localparam int P_DRV_HI = 6;
  localparam int P_DRV_LO = 5;
  localparam int P_HFM = 4;

  // writable masks: volatile and non-volatile images
  localparam logic [7:0] SR1_WR_MASK = 8'hfc;
  localparam logic [7:0] SR2_VOL_MASK = 8'h43;
  localparam logic [7:0] SR2_LOCK_MASK = 8'h38;
  localparam logic [7:0] SR3_VOL_MASK = 8'hf0;
  localparam logic [7:0] SR3_NV_MASK = 8'h90;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [2:0] BP_NONE = 3'h0;

  // register select on the status-register bus
  localparam logic [1:0] SEL_SR1 = 2'h0;
  localparam logic [1:0] SEL_SR2 = 2'h1;
  localparam logic [1:0] SEL_SR3 = 2'h2;

  // protect-mode encodings {high, low}
  localparam logic [1:0] PM_SOFT = 2'h0;
  localparam logic [1:0] PM_HW = 2'h1;

  typedef struct packed {
    logic [7:0] sr1;
    logic [7:0] sr2;
    logic [7:0] sr3;
  } sr_image_t;

  typedef struct packed {
    logic write_enable;
    logic write_disable;
    logic vol_write_enable;
    logic write_status;
    logic page_program;
    logic sector_erase;
    logic block_erase;
    logic chip_erase;
    logic suspend;
    logic resume;
    logic soft_reset;
  } instr_t;

  typedef struct packed {
    logic [1:0] drive_strength;
    logic high_freq_mode;
    logic quad_enable;
    logic hold_active;
    logic reset_active;
    logic wp_active;
    logic complement_map;
    logic granularity_select;
    logic direction_select;
    logic [2:0] block_protect;
    logic array_unprotected;
  } config_out_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_NV_BUSY = 3'b010,
    ST_OP_BUSY = 3'b100
  } op_state_t;

endpackage

/* File: op_timer.sv */
// Purpose: counts out the duration of an embedded operation
// Assumes: start is a one-cycle pulse while idle
// Notes: done pulses one cycle after the count runs out

`timescale 1ns/1ps

module op_timer #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [CNT_W-1:0] length,
  output logic done
);
  import status_reg_pkg::*;

  typedef struct packed {
    logic running;
    logic done;
    logic [CNT_W-1:0] count;
  } timer_state_t;

  timer_state_t state_ff;
  timer_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.done = 1'b0;
    if (start) begin
      nxt_state.running = 1'b1;
      nxt_state.count = length;
    end else if (state_ff.running) begin
      if (state_ff.count == '0) begin
        nxt_state.running = 1'b0;
        nxt_state.done = 1'b1;
      end else begin
        nxt_state.count = state_ff.count - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign done = state_ff.done;
endmodule // op_timer

/* File: flash_status_register_bank.sv */
// Purpose: three status/configuration registers of a serial NOR flash
// Assumes: instructions arrive decoded as one-cycle strobes in instr
// Notes: non-volatile cells modelled as flops; power cycle is reset
//
// What this block does
// - bit7 of reg1: low protect-mode bit
// - bit6 of reg1: sector or block granularity
// - bit5 of reg1: top-down or bottom-up direction
// - bits4:2 block protect; zero means unprotected while complement bit is clear
// - bit1 read-only write enable latch gates operations
// - bit0 busy set during program, erase, write
// - while busy ignore all but status read
// - busy clears when operation completes
// - write enable instruction sets latch
// - latch cleared at reset and after non-volatile writes, program and erase
// - bit7 of reg2: read-only suspend flag
// - bit6 of reg2: complement protection map
// - bits5:3 of reg2: one-time security locks
// - bit0 of reg2: high protect-mode bit
// - bit7 of reg3: hold or reset role
// - bits6:5 of reg3: volatile drive strength
// - bit4 of reg3: high frequency mode
// - configuration bits except drive strength and locks have volatile and non-volatile copies
// - volatile copies loaded at reset and soft reset
// - volatile enable before write targets volatile copies
// - hardware protect with pin low and quad off refuses writes to reg1 and reg2
// - status flags never altered by volatile register writes

`timescale 1ns/1ps

module flash_status_register_bank #(
  parameter int CNT_W = 16,
  parameter logic [CNT_W-1:0] NV_WRITE_CYCLES = 16'h0100,
  parameter logic [CNT_W-1:0] PROGRAM_CYCLES = 16'h0200,
  parameter logic [CNT_W-1:0] ERASE_CYCLES = 16'h0400
) (
  input wire logic clk,
  input wire logic reset,
  input wire status_reg_pkg::instr_t instr,
  input wire logic [1:0] wr_sel,
  input wire logic [7:0] wr_data,
  input wire logic [1:0] rd_sel,
  input wire logic write_protect_n,
  output logic [7:0] rd_data,
  output logic busy,
  output logic op_start,
  output status_reg_pkg::config_out_t cfg
);
  import status_reg_pkg::*;

  typedef struct packed {
    sr_image_t nv;
    sr_image_t vol;
    logic vol_armed;
    logic write_enable_latch;
    logic suspend_flag;
    logic power_lock;
    logic load_pending;
    op_state_t op;
    logic [7:0] rd_data;
  } bank_state_t;

  bank_state_t state_ff;
  bank_state_t nxt_state;
  logic timer_start;
  logic timer_done;
  logic [CNT_W-1:0] timer_len;
  logic sr12_locked;
  logic any_op;
  logic nv_write;
  logic vol_write;

  // read image with live flags merged, reserved lanes zero
  function automatic logic [7:0] read_byte(input bank_state_t s, input logic [1:0] sel);
    logic [7:0] b;
    b = BYTE_ZERO;
    case (sel)
      SEL_SR1: begin
        b = s.vol.sr1 & SR1_WR_MASK;
        b[P_WEL] = s.write_enable_latch;
        b[P_BUSY] = (s.op != ST_IDLE);
      end
      SEL_SR2: begin
        b = (s.vol.sr2 & SR2_VOL_MASK) | (s.nv.sr2 & SR2_LOCK_MASK);
        b[P_SUSP] = s.suspend_flag;
      end
      SEL_SR3: b = s.vol.sr3 & SR3_VOL_MASK;
      default: b = BYTE_ZERO;
    endcase
    return b;
  endfunction

  // volatile image from non-volatile; drive bits have no backing cell
  function automatic sr_image_t load_vol(input sr_image_t nv);
    sr_image_t v;
    v.sr1 = nv.sr1 & SR1_WR_MASK;
    v.sr2 = nv.sr2 & SR2_VOL_MASK;
    v.sr3 = nv.sr3 & SR3_NV_MASK;
    return v;
  endfunction

  always_comb begin
    sr12_locked = 1'b0;
    case ({state_ff.vol.sr2[P_PROT_HIGH], state_ff.vol.sr1[P_PROT_LOW]})
      PM_SOFT: sr12_locked = 1'b0;
      // pin protection only while quad mode is off
      PM_HW: sr12_locked = ~write_protect_n & ~state_ff.vol.sr2[P_QUAD];
      default: sr12_locked = 1'b1;
    endcase
    sr12_locked = sr12_locked | state_ff.power_lock;
  end

  // everything except status read is dropped while busy
  assign any_op = (state_ff.op == ST_IDLE) && !state_ff.load_pending;
  assign nv_write = any_op && instr.write_status && state_ff.write_enable_latch && !state_ff.vol_armed;
  assign vol_write = any_op && instr.write_status && state_ff.vol_armed;

  always_comb begin
    nxt_state = state_ff;
    timer_start = 1'b0;
    timer_len = NV_WRITE_CYCLES;
    nxt_state.rd_data = read_byte(state_ff, rd_sel);
    if (state_ff.load_pending) begin
      nxt_state.vol = load_vol(state_ff.nv);
      nxt_state.load_pending = 1'b0;
    end
    case (state_ff.op)
      ST_IDLE: begin
        if (any_op) begin
          if (instr.soft_reset) begin
            nxt_state.load_pending = 1'b1;
            nxt_state.write_enable_latch = 1'b0;
            nxt_state.suspend_flag = 1'b0;
            nxt_state.vol_armed = 1'b0;
            // lock-down released by soft reset
            if ({state_ff.nv.sr2[P_PROT_HIGH], state_ff.nv.sr1[P_PROT_LOW]} == {1'b1, 1'b0}) begin
              nxt_state.nv.sr2[P_PROT_HIGH] = 1'b0;
            end
            nxt_state.power_lock = 1'b0;
          end else if (instr.write_enable) begin
            nxt_state.write_enable_latch = 1'b1;
            nxt_state.vol_armed = 1'b0;
          end else if (instr.vol_write_enable) begin
            nxt_state.vol_armed = 1'b1;
          end else if (instr.write_disable) begin
            nxt_state.write_enable_latch = 1'b0;
            nxt_state.vol_armed = 1'b0;
          end else if (instr.suspend) begin
            nxt_state.suspend_flag = 1'b1;
          end else if (instr.resume) begin
            nxt_state.suspend_flag = 1'b0;
          end else if (vol_write) begin
            nxt_state.vol_armed = 1'b0;
            // flags untouched; drive bits are volatile only
            case (wr_sel)
              SEL_SR1: if (!sr12_locked) nxt_state.vol.sr1 = wr_data & SR1_WR_MASK;
              SEL_SR2: if (!sr12_locked) nxt_state.vol.sr2 = wr_data & SR2_VOL_MASK;
              SEL_SR3: nxt_state.vol.sr3 = wr_data & SR3_VOL_MASK;
              default: nxt_state.vol_armed = 1'b0;
            endcase
          end else if (nv_write) begin
            nxt_state.write_enable_latch = 1'b0;
            timer_start = 1'b1;
            nxt_state.op = ST_NV_BUSY;
            case (wr_sel)
              SEL_SR1: if (!sr12_locked) nxt_state.nv.sr1 = wr_data & SR1_WR_MASK;
              SEL_SR2: if (!sr12_locked) begin
                // locks only ever set
                nxt_state.nv.sr2 = (wr_data & SR2_VOL_MASK) | ((wr_data | state_ff.nv.sr2) & SR2_LOCK_MASK);
                nxt_state.vol.sr2 = wr_data & SR2_VOL_MASK;
              end
              SEL_SR3: nxt_state.nv.sr3 = wr_data & SR3_NV_MASK;
              default: nxt_state.op = ST_NV_BUSY;
            endcase
            if (wr_sel == SEL_SR1 && !sr12_locked) begin
              nxt_state.vol.sr1 = wr_data & SR1_WR_MASK;
              // power-supply lock-down takes hold at once
              nxt_state.power_lock = wr_data[P_PROT_LOW] == 1'b0 && state_ff.nv.sr2[P_PROT_HIGH];
            end
            if (wr_sel == SEL_SR3) begin
              nxt_state.vol.sr3 = (state_ff.vol.sr3 & ~SR3_NV_MASK) | (wr_data & SR3_NV_MASK);
            end
          end else if (state_ff.write_enable_latch &&
                       (instr.page_program | instr.sector_erase | instr.block_erase | instr.chip_erase)) begin
            nxt_state.write_enable_latch = 1'b0;
            timer_start = 1'b1;
            timer_len = instr.page_program ? PROGRAM_CYCLES : ERASE_CYCLES;
            nxt_state.op = ST_OP_BUSY;
          end
        end
      end
      ST_NV_BUSY, ST_OP_BUSY: begin
        timer_len = NV_WRITE_CYCLES;
        if (timer_done) nxt_state.op = ST_IDLE;
      end
      default: nxt_state.op = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= '0;
      state_ff.op <= ST_IDLE;
      state_ff.load_pending <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  op_timer #(
    .CNT_W(CNT_W)
  ) u_op_timer (
    .clk(clk),
    .reset(reset),
    .start(timer_start),
    .length(timer_len),
    .done(timer_done)
  );

  assign rd_data = state_ff.rd_data;
  assign busy = (state_ff.op != ST_IDLE);
  assign op_start = timer_start && (nxt_state.op == ST_OP_BUSY);

  always_comb begin
    cfg.drive_strength = {state_ff.vol.sr3[P_DRV_HI], state_ff.vol.sr3[P_DRV_LO]};
    cfg.high_freq_mode = state_ff.vol.sr3[P_HFM];
    cfg.quad_enable = state_ff.vol.sr2[P_QUAD];
    cfg.hold_active = ~state_ff.vol.sr2[P_QUAD] & ~state_ff.vol.sr3[P_PIN_ROLE];
    cfg.reset_active = ~state_ff.vol.sr2[P_QUAD] & state_ff.vol.sr3[P_PIN_ROLE];
    cfg.wp_active = ~state_ff.vol.sr2[P_QUAD];
    cfg.complement_map = state_ff.vol.sr2[P_CMP];
    cfg.granularity_select = state_ff.vol.sr1[P_GRAN];
    cfg.direction_select = state_ff.vol.sr1[P_DIR];
    cfg.block_protect = state_ff.vol.sr1[P_BP_HI:P_BP_LO];
    cfg.array_unprotected = (state_ff.vol.sr1[P_BP_HI:P_BP_LO] == BP_NONE) & ~state_ff.vol.sr2[P_CMP];
  end
endmodule // flash_status_register_bank

/* File: flash_status_register_bank_monitor.sv */
// Purpose: port checks for the status register bank
// Assumes: one clock, synchronous reset
// Notes: busy span is the op length plus 2
`timescale 1ns/1ps
module flash_status_register_bank_monitor #(
  parameter int CNT_W = 16,
  parameter logic [CNT_W-1:0] NV_WRITE_CYCLES = 16'h0100,
  parameter logic [CNT_W-1:0] PROGRAM_CYCLES = 16'h0200,
  parameter logic [CNT_W-1:0] ERASE_CYCLES = 16'h0400
) (
  input wire logic clk,
  input wire logic reset,
  input wire status_reg_pkg::instr_t instr,
  input wire logic [1:0] rd_sel,
  input wire logic [7:0] rd_data,
  input wire logic busy,
  input wire logic op_start,
  input wire status_reg_pkg::config_out_t cfg
);
  import status_reg_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] len_ff;
  // length latched at start, so program and erase spans differ
  always_ff @(posedge clk) begin
    cnt_ff <= (reset || !busy) ? '0 : cnt_ff + 1'b1;
    if (op_start) len_ff <= instr.page_program ? PROGRAM_CYCLES : ERASE_CYCLES;
    else if (!busy) len_ff <= NV_WRITE_CYCLES;
  end
  chk_res_three: assert property (rd_sel == SEL_SR3 |=> rd_data[3:1] == 3'h0)
    else $error("reserved bits set in third register");
  chk_res_two: assert property (rd_sel == SEL_SR2 |=> rd_data[2] == 1'b0)
    else $error("reserved bit set in second register");
  chk_busy_view: assert property (rd_sel == SEL_SR1 |=> rd_data[P_BUSY] == $past(busy))
    else $error("busy bit differs from busy output");
  chk_start_idle: assert property (op_start |-> !busy)
    else $error("operation started while busy");
  chk_start_busy: assert property (op_start |=> busy)
    else $error("busy missing after start");
  chk_busy_len: assert property ($fell(busy) |-> cnt_ff == len_ff + 2)
    else $error("busy span wrong");
  chk_unprot_bp: assert property (cfg.block_protect == BP_NONE && !cfg.complement_map |-> cfg.array_unprotected)
    else $error("array protected with empty field");
  chk_quad_pins: assert property (cfg.quad_enable |-> !(cfg.wp_active || cfg.hold_active || cfg.reset_active))
    else $error("pin function active in quad mode");
  cover property (op_start);
  cover property ($fell(busy));
  cover property (cfg.quad_enable && !busy);
endmodule // flash_status_register_bank_monitor

bind flash_status_register_bank flash_status_register_bank_monitor #(.CNT_W(CNT_W),
  .NV_WRITE_CYCLES(NV_WRITE_CYCLES), .PROGRAM_CYCLES(PROGRAM_CYCLES), .ERASE_CYCLES(ERASE_CYCLES))
  i_flash_status_register_bank_monitor (.clk(clk), .reset(reset), .instr(instr), .rd_sel(rd_sel),
  .rd_data(rd_data), .busy(busy), .op_start(op_start), .cfg(cfg));

/* File: host_cmd_model.sv */
// Purpose: host side turning bench requests into instruction strobes
// Assumes: one request per cycle
// Notes: idle write data toggles so stale bytes never look valid
`timescale 1ns/1ps
module host_cmd_model (
  input wire logic clk,
  input wire logic reset,
  input wire status_reg_pkg::instr_t cmd,
  input wire logic [1:0] sel,
  input wire logic [7:0] data,
  output status_reg_pkg::instr_t instr,
  output logic [1:0] wr_sel,
  output logic [7:0] wr_data
);
  import status_reg_pkg::*;
  logic pend_ff;
  instr_t nxt_instr;
  // volatile pair split over two cycles, nothing in between
  always_comb begin
    nxt_instr = reset ? '0 : cmd;
    if (cmd.vol_write_enable && cmd.write_status) nxt_instr.write_status = 1'b0;
    if (pend_ff) nxt_instr.write_status = 1'b1;
  end
  // one assignment per signal per edge
  always @(posedge clk) begin
    pend_ff <= !reset && cmd.vol_write_enable && cmd.write_status;
    instr <= nxt_instr;
    wr_sel <= sel;
    wr_data <= reset ? 8'h00 : ((cmd.write_status || pend_ff) ? data : ~wr_data);
  end
endmodule // host_cmd_model

/* File: flash_status_register_bank_tb.sv */
// Purpose: self-checking bench for the status register bank
// Assumes: op lengths cut to 4 cycles
// Notes: host model turns requests into strobes
`timescale 1ns/1ps
module flash_status_register_bank_tb;
  import status_reg_pkg::*;
  localparam instr_t T_WEN = '{write_enable: 1'b1, default: 1'b0};
  localparam instr_t T_WDIS = '{write_disable: 1'b1, default: 1'b0};
  localparam instr_t T_VWR = '{vol_write_enable: 1'b1, write_status: 1'b1, default: 1'b0};
  localparam instr_t T_WST = '{write_status: 1'b1, default: 1'b0};
  localparam instr_t T_PROG = '{page_program: 1'b1, default: 1'b0};
  localparam instr_t T_SUS = '{suspend: 1'b1, default: 1'b0};
  localparam instr_t T_RES = '{resume: 1'b1, default: 1'b0};
  localparam instr_t T_SRST = '{soft_reset: 1'b1, default: 1'b0};
  logic clk, reset, write_protect_n, busy, op_start;
  logic [1:0] sel, rd_sel, wr_sel, k;
  logic [7:0] data, wr_data, rd_data, r, d, s2;
  instr_t cmd, instr, ers;
  config_out_t cfg;
  int num_errors, tests_run;
  host_cmd_model i_host_cmd_model (.clk(clk), .reset(reset), .cmd(cmd), .sel(sel), .data(data),
    .instr(instr), .wr_sel(wr_sel), .wr_data(wr_data));
  flash_status_register_bank #(.NV_WRITE_CYCLES(16'h0004), .PROGRAM_CYCLES(16'h0004),
    .ERASE_CYCLES(16'h0004)) i_flash_status_register_bank (.clk(clk), .reset(reset), .instr(instr),
    .wr_sel(wr_sel), .wr_data(wr_data), .rd_sel(rd_sel), .write_protect_n(write_protect_n),
    .rd_data(rd_data), .busy(busy), .op_start(op_start), .cfg(cfg));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic issue(input instr_t c, input logic [1:0] s, input logic [7:0] v);
    cmd = c;
    sel = s;
    data = v;
    @(posedge clk);
    #1 cmd = '0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [1:0] s);
    rd_sel = s;
    @(posedge clk);
    #1 r = rd_data;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 40 && busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    if (busy !== 1'b0) begin
      num_errors++;
      $display("mismatch at %0t: busy never cleared", $time);
    end
  endtask
  function automatic logic [7:0] vol_exp(input logic [1:0] s, input logic [7:0] v);
    if (s == SEL_SR1) return v & SR1_WR_MASK;
    if (s == SEL_SR2) return v & SR2_VOL_MASK;
    return v & SR3_VOL_MASK;
  endfunction
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    end_of_test();
  end
  initial begin
    num_errors = 0;
    tests_run = 0;
    reset = 1'b1;
    cmd = '0;
    sel = 2'h0;
    data = 8'h00;
    rd_sel = 2'h0;
    write_protect_n = 1'b1;
    void'($urandom(93222));
    repeat (8) @(posedge clk);
    #1 reset = 1'b0;
    @(posedge clk);
    #1;
    for (int s = 0; s < 3; s++) begin
      rd(2'(s));
      chk(r, 8'h00);
    end
    issue(T_WEN, 2'h0, 8'h00);
    rd(SEL_SR1);
    chk(r, 8'h02);
    issue(T_WDIS, 2'h0, 8'h00);
    rd(SEL_SR1);
    chk(r, 8'h00);
    issue(T_PROG, 2'h0, 8'h00);
    chk({7'h0, busy}, 8'h00);
    s2 = 8'h00;
    // second register keeps its high protect bit clear so writes stay open
    for (int i = 0; i < 6; i++) begin
      k = 2'(i % 3);
      d = 8'($urandom) & (k == SEL_SR2 ? 8'hfe : 8'hff);
      issue(T_VWR, k, d);
      rd(k);
      chk(r, vol_exp(k, d));
      if (k == SEL_SR1) chk({cfg.granularity_select, cfg.direction_select, cfg.block_protect, 3'h0}, {d[6:2], 3'h0});
      if (k == SEL_SR1) chk({7'h0, cfg.array_unprotected}, {7'h0, (d[4:2] == 3'h0) && !s2[6]});
      if (k == SEL_SR2) chk({5'h0, cfg.complement_map, cfg.quad_enable, cfg.wp_active}, {5'h0, d[6], d[1], ~d[1]});
      if (k == SEL_SR2) s2 = d;
      if (k == SEL_SR3) chk({cfg.drive_strength, cfg.high_freq_mode, 5'h0}, {d[6:4], 5'h0});
      if (k == SEL_SR3) chk({6'h0, cfg.hold_active, cfg.reset_active}, {6'h0, ~s2[1] & ~d[7], ~s2[1] & d[7]});
    end
    issue(T_WEN, 2'h0, 8'h00);
    issue(T_WST, SEL_SR2, 8'h08);
    rd(SEL_SR1);
    chk(r & 8'h03, 8'h01);
    issue(T_WEN, 2'h0, 8'h00);
    wait_idle();
    rd(SEL_SR1);
    chk(r & 8'h03, 8'h00);
    rd(SEL_SR2);
    chk(r & SR2_LOCK_MASK, 8'h08);
    issue(T_WEN, 2'h0, 8'h00);
    issue(T_PROG, 2'h0, 8'h00);
    chk({7'h0, busy}, 8'h01);
    wait_idle();
    rd(SEL_SR1);
    chk(r & 8'h03, 8'h00);
    // every erase kind must start busy and drop the latch
    for (int e = 0; e < 3; e++) begin
      ers = '0;
      ers.sector_erase = (e == 0);
      ers.block_erase = (e == 1);
      ers.chip_erase = (e == 2);
      issue(T_WEN, 2'h0, 8'h00);
      issue(ers, 2'h0, 8'h00);
      chk({7'h0, busy}, 8'h01);
      wait_idle();
      rd(SEL_SR1);
      chk(r & 8'h03, 8'h00);
    end
    issue(T_SUS, 2'h0, 8'h00);
    rd(SEL_SR2);
    chk(r & 8'h80, 8'h80);
    issue(T_RES, 2'h0, 8'h00);
    rd(SEL_SR2);
    chk(r & 8'h80, 8'h00);
    issue(T_VWR, SEL_SR2, 8'h00);
    issue(T_VWR, SEL_SR1, 8'h83);
    chk({7'h0, cfg.array_unprotected}, 8'h01);
    write_protect_n = 1'b0;
    issue(T_VWR, SEL_SR1, 8'h1c);
    rd(SEL_SR1);
    chk(r, 8'h80);
    write_protect_n = 1'b1;
    // third register is never refused; drive bits have no backing cell
    issue(T_WEN, 2'h0, 8'h00);
    issue(T_WST, SEL_SR3, 8'hf0);
    wait_idle();
    issue(T_SRST, 2'h0, 8'h00);
    rd(SEL_SR1);
    chk(r, 8'h00);
    rd(SEL_SR2);
    chk(r, 8'h08);
    rd(SEL_SR3);
    chk(r, 8'h90);
    chk({6'h0, cfg.hold_active, cfg.reset_active}, 8'h01);
    issue(T_VWR, SEL_SR2, 8'h01);
    issue(T_VWR, SEL_SR1, 8'h1c);
    rd(SEL_SR1);
    chk(r, 8'h00);
    issue(T_VWR, SEL_SR3, 8'h60);
    rd(SEL_SR3);
    chk(r, 8'h60);
    end_of_test();
  end
endmodule // flash_status_register_bank_tb
